//--- design/meas_pkg.sv
// Purpose: shared constants and carriers for the voltage measurement sequencer
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: register map sits on an AHB-Lite slave
package meas_pkg;
    localparam int CLK_MHZ = 100;
    localparam int DATA_W = 24;
    localparam int CHAN_W = 4;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_SETTLE = 8'h08;
    localparam logic [7:0] OFF_MULT = 8'h0C;
    localparam logic [7:0] OFF_OFFSET = 8'h10;
    localparam logic [7:0] OFF_RESULT = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFF_IRQ_EN = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h24;
    // cfg register field positions
    localparam int CFG_RANGE_LSB = 0;
    localparam int CFG_NOTCH_LSB = 4;
    localparam int CFG_CHAN_LSB = 8;
    localparam int CFG_DIFF_BIT = 12;
    localparam int CFG_EXC_EN_BIT = 13;
    localparam int CFG_IREV_BIT = 14;
    localparam int CFG_XREV_BIT = 15;
    localparam int CFG_EXC_MV_LSB = 16;
    // reset values
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] SETTLE_RESET = 32'h0000_0064;
    localparam logic [31:0] MULT_RESET = 32'h0001_0000;
    localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
    localparam logic [31:0] NAN_CODE = 32'h7FC0_0000;
    // settling delay unit: microseconds, cycles per unit derived from rate
    localparam int SETTLE_UNIT_NS = 1000;
    localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_NS * CLK_MHZ / 1000;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVR = 1;

    typedef struct packed {
        logic [3:0] range_sel;
        logic [3:0] first_notch_frequency;
        logic [CHAN_W-1:0] channel;
        logic differential_channel;
        logic exc_enable;
        logic input_reverse;
        logic excitation_reverse;
        logic [15:0] excitation_level_mv;
    } meas_cfg_s;

    typedef struct packed {
        logic [3:0] gain;
        logic [3:0] first_notch_frequency;
        logic [CHAN_W-1:0] mux_high;
        logic [CHAN_W-1:0] mux_low;
        logic low_to_ground;
        logic swap_inputs;
        logic exc_on;
        logic exc_invert;
        logic [15:0] excitation_level_mv;
    } afe_ctrl_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_GAIN = 4'b0001,
        ST_EXC = 4'b0011,
        ST_MUX = 4'b0010,
        ST_SETTLE = 4'b0110,
        ST_CONV = 4'b0111,
        ST_WAIT = 4'b0101,
        ST_NEXT = 4'b0100,
        ST_SCALE = 4'b1100,
        ST_DONE = 4'b1101
    } seq_state_e;
endpackage

//--- design/settle_timer.sv
// Purpose: settling delay counter with a microsecond tick divider
// Assumes: load pulse starts a count of settle units
// Notes: a zero delay still waits one unit tick
module settle_timer #(
    parameter int UNIT_CYC = meas_pkg::SETTLE_UNIT_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [31:0] units,
    output logic expired
);
    logic [15:0] div;
    logic [31:0] remain;
    logic running;
    logic tick;

    assign tick = running && (div == 16'(UNIT_CYC - 1));

    always_ff @(posedge mclk) begin
        if (!reset_n || load || tick) begin
            div <= 16'h0000;
        end else if (running) begin
            div <= div + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            running <= 1'b0;
            remain <= 32'h0000_0000;
            expired <= 1'b0;
        end else if (load) begin
            running <= 1'b1;
            remain <= (units == 32'h0000_0000) ? 32'h0000_0001 : units;
            expired <= 1'b0;
        end else if (tick) begin
            remain <= remain - 32'h0000_0001;
            if (remain == 32'h0000_0001) begin
                running <= 1'b0;
                expired <= 1'b1;
            end
        end else begin
            expired <= 1'b0;
        end
    end
endmodule // settle_timer

//--- design/scale_unit.sv
// Purpose: result = raw * mult (Q16.16) + offset, or not-a-number on overrange
// Assumes: start pulse with stable operands
// Notes: one cycle multiply, one cycle add
module scale_unit (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic signed [31:0] raw,
    input wire logic overrange,
    input wire logic signed [31:0] mult,
    input wire logic signed [31:0] offset,
    output logic valid,
    output logic [31:0] result
);
    logic signed [63:0] prod;
    logic stage;
    logic ovr_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prod <= 64'sh0;
            stage <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            stage <= start;
            if (start) begin
                prod <= raw * mult;
                ovr_q <= overrange;
            end
        end
    end

    // multiply first, then offset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            valid <= 1'b0;
            result <= 32'h0000_0000;
        end else begin
            valid <= stage;
            if (stage) begin
                result <= ovr_q ? meas_pkg::NAN_CODE : (32'(prod >>> 16) + offset);
            end
        end
    end
endmodule // scale_unit

//--- design/voltage_measurement_sequencer.sv
// Purpose: sequences one voltage measurement over an AHB-Lite register file
// Assumes: converter answers conv_start with conv_valid later; config stable while busy
// Notes: zero wait state slave; one cycle per setup step
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
module voltage_measurement_sequencer (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output meas_pkg::afe_ctrl_s afe,
    output logic conv_start,
    input wire logic conv_valid,
    input wire logic signed [meas_pkg::DATA_W-1:0] conv_data,
    input wire logic conv_overrange,
    output logic busy,
    output logic done,
    output logic irq
);
    localparam int DW = meas_pkg::DATA_W;

    meas_pkg::seq_state_e state;
    meas_pkg::meas_cfg_s cfg;
    logic [31:0] cfg_word;
    logic [31:0] settle_delay;
    logic [31:0] mult;
    logic [31:0] offset;
    logic [31:0] result;
    logic [meas_pkg::IRQ_W-1:0] irq_stat;
    logic [meas_pkg::IRQ_W-1:0] irq_en;
    logic [1:0] pass;
    logic [1:0] pass_total;
    logic signed [31:0] accum;
    logic ovr_seen;
    logic settle_load;
    logic settle_done;
    logic scale_go;
    logic scale_valid;
    logic [31:0] scale_result;
    logic start_req;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [1:0] dirs;
    logic signed [31:0] sample;

    // bus: zero wait state, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_write <= hsel && htrans[1] && hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                meas_pkg::OFF_CTRL: hrdata <= 32'h0000_0000;
                meas_pkg::OFF_CFG: hrdata <= cfg_word;
                meas_pkg::OFF_SETTLE: hrdata <= settle_delay;
                meas_pkg::OFF_MULT: hrdata <= mult;
                meas_pkg::OFF_OFFSET: hrdata <= offset;
                meas_pkg::OFF_RESULT: hrdata <= result;
                meas_pkg::OFF_STATUS: hrdata <= {28'h000_0000, state};
                meas_pkg::OFF_IRQ_STAT: hrdata <= 32'(irq_stat);
                meas_pkg::OFF_IRQ_EN: hrdata <= 32'(irq_en);
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfg_word <= meas_pkg::CFG_RESET;
            settle_delay <= meas_pkg::SETTLE_RESET;
            mult <= meas_pkg::MULT_RESET;
            offset <= meas_pkg::OFFSET_RESET;
            irq_en <= '0;
        end else if (dp_write && !busy) begin
            case (dp_addr)
                meas_pkg::OFF_CFG: cfg_word <= hwdata;
                meas_pkg::OFF_SETTLE: settle_delay <= hwdata;
                meas_pkg::OFF_MULT: mult <= hwdata;
                meas_pkg::OFF_OFFSET: offset <= hwdata;
                meas_pkg::OFF_IRQ_EN: irq_en <= hwdata[meas_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end else if (dp_write && dp_addr == meas_pkg::OFF_IRQ_EN) begin
            irq_en <= hwdata[meas_pkg::IRQ_W-1:0];
        end
    end

    // start is a write of bit 0 to ctrl; ignored while busy
    assign start_req = dp_write && (dp_addr == meas_pkg::OFF_CTRL) && hwdata[0] && !busy;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfg <= '0;
        end else if (start_req) begin
            cfg.range_sel <= cfg_word[meas_pkg::CFG_RANGE_LSB +: 4];
            cfg.first_notch_frequency <= cfg_word[meas_pkg::CFG_NOTCH_LSB +: 4];
            cfg.channel <= cfg_word[meas_pkg::CFG_CHAN_LSB +: meas_pkg::CHAN_W];
            cfg.differential_channel <= cfg_word[meas_pkg::CFG_DIFF_BIT];
            cfg.exc_enable <= cfg_word[meas_pkg::CFG_EXC_EN_BIT];
            cfg.input_reverse <= cfg_word[meas_pkg::CFG_IREV_BIT];
            cfg.excitation_reverse <= cfg_word[meas_pkg::CFG_XREV_BIT];
            cfg.excitation_level_mv <= cfg_word[meas_pkg::CFG_EXC_MV_LSB +: 16];
        end
    end

    // input reverse only meaningful on a differential channel
    always_comb begin
        dirs = {cfg.excitation_reverse && cfg.exc_enable,
                cfg.input_reverse && cfg.differential_channel};
        pass_total = 2'd0;
        case (dirs)
            2'b00: pass_total = 2'd0;
            2'b01: pass_total = 2'd1;
            2'b10: pass_total = 2'd1;
            default: pass_total = 2'd3;
        endcase
    end

    // pass bit0 swaps inputs, bit1 inverts excitation (packed per enabled flag)
    logic swap_now;
    logic xinv_now;
    always_comb begin
        swap_now = 1'b0;
        xinv_now = 1'b0;
        case (dirs)
            2'b01: swap_now = pass[0];
            2'b10: xinv_now = pass[0];
            2'b11: begin
                swap_now = pass[0];
                xinv_now = pass[1];
            end
            default: ;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= meas_pkg::ST_IDLE;
            pass <= 2'd0;
        end else begin
            case (state)
                meas_pkg::ST_IDLE: if (start_req) begin
                    state <= meas_pkg::ST_GAIN;
                    pass <= 2'd0;
                end
                meas_pkg::ST_GAIN: state <= meas_pkg::ST_EXC;
                meas_pkg::ST_EXC: state <= meas_pkg::ST_MUX;
                meas_pkg::ST_MUX: state <= meas_pkg::ST_SETTLE;
                meas_pkg::ST_SETTLE: state <= meas_pkg::ST_CONV;
                meas_pkg::ST_CONV: if (settle_done) state <= meas_pkg::ST_WAIT;
                meas_pkg::ST_WAIT: if (conv_valid) state <= meas_pkg::ST_NEXT;
                meas_pkg::ST_NEXT: begin
                    if (pass == pass_total) begin
                        state <= meas_pkg::ST_SCALE;
                    end else begin
                        pass <= pass + 2'd1;
                        state <= meas_pkg::ST_MUX;
                    end
                end
                meas_pkg::ST_SCALE: if (scale_valid) state <= meas_pkg::ST_DONE;
                meas_pkg::ST_DONE: state <= meas_pkg::ST_IDLE;
                default: state <= meas_pkg::ST_IDLE;
            endcase
        end
    end

    assign settle_load = (state == meas_pkg::ST_SETTLE);
    assign conv_start = (state == meas_pkg::ST_CONV) && settle_done;
    assign busy = (state != meas_pkg::ST_IDLE);
    assign done = (state == meas_pkg::ST_DONE);
    assign scale_go = (state == meas_pkg::ST_NEXT) && (pass == pass_total);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            afe <= '0;
        end else if (state == meas_pkg::ST_IDLE) begin
            afe.exc_on <= 1'b0;
        end else begin
            if (state == meas_pkg::ST_GAIN) begin
                afe.gain <= cfg.range_sel;
                afe.first_notch_frequency <= cfg.first_notch_frequency;
            end
            if (state == meas_pkg::ST_EXC) begin
                afe.exc_on <= cfg.exc_enable;
                afe.excitation_level_mv <= cfg.excitation_level_mv;
            end
            if (state == meas_pkg::ST_MUX) begin
                afe.mux_high <= cfg.channel;
                afe.mux_low <= cfg.channel;
                afe.low_to_ground <= !cfg.differential_channel;
                afe.swap_inputs <= swap_now;
                afe.exc_invert <= xinv_now;
            end
        end
    end

    // reversed passes are negated so summing cancels offsets
    assign sample = (afe.swap_inputs ^ afe.exc_invert) ? -32'(conv_data) : 32'(conv_data);

    always_ff @(posedge mclk) begin
        if (!reset_n || start_req) begin
            accum <= 32'sh0;
            ovr_seen <= 1'b0;
        end else if (state == meas_pkg::ST_WAIT && conv_valid) begin
            accum <= accum + sample;
            ovr_seen <= ovr_seen | conv_overrange;
        end
    end

    logic signed [31:0] averaged;
    assign averaged = (pass_total == 2'd3) ? (accum >>> 2) :
                      (pass_total == 2'd1) ? (accum >>> 1) : accum;

    settle_timer u_settle (
        .mclk(mclk),
        .reset_n(reset_n),
        .load(settle_load),
        .units(settle_delay),
        .expired(settle_done)
    );

    scale_unit u_scale (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(scale_go),
        .raw(averaged),
        .overrange(ovr_seen),
        .mult(mult),
        .offset(offset),
        .valid(scale_valid),
        .result(scale_result)
    );

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            result <= 32'h0000_0000;
        end else if (scale_valid) begin
            result <= scale_result;
        end
    end

    // set wins over a clear in the same cycle
    logic [meas_pkg::IRQ_W-1:0] irq_set;
    logic [meas_pkg::IRQ_W-1:0] irq_clr;
    assign irq_set = {scale_valid && ovr_seen, scale_valid};
    assign irq_clr = (dp_write && dp_addr == meas_pkg::OFF_IRQ_CLR) ?
                     hwdata[meas_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat & irq_en);

    chk_gain_first: assert property (@(posedge mclk) disable iff (!reset_n)
        start_req |=> state == meas_pkg::ST_GAIN ##1 afe.gain == cfg.range_sel)
        else $error("gain not set first");
    chk_exc_before_mux: assert property (@(posedge mclk) disable iff (!reset_n)
        state == meas_pkg::ST_EXC |=> afe.exc_on == cfg.exc_enable && state == meas_pkg::ST_MUX)
        else $error("excitation not set before mux");
    chk_mux_ground: assert property (@(posedge mclk) disable iff (!reset_n)
        state == meas_pkg::ST_MUX |=> afe.low_to_ground == !cfg.differential_channel)
        else $error("mux low side wrong");
    chk_conv_after_settle: assert property (@(posedge mclk) disable iff (!reset_n)
        conv_start |-> settle_done && $past(state) == meas_pkg::ST_CONV)
        else $error("conversion before settle");
    chk_settle_then_conv: assert property (@(posedge mclk) disable iff (!reset_n)
        state == meas_pkg::ST_CONV && settle_done |=> state == meas_pkg::ST_WAIT)
        else $error("no conversion after settle");
    chk_pass_repeat: assert property (@(posedge mclk) disable iff (!reset_n)
        state == meas_pkg::ST_NEXT && pass != pass_total |=> state == meas_pkg::ST_MUX)
        else $error("reverse pass skipped");
    chk_scale_result: assert property (@(posedge mclk) disable iff (!reset_n)
        scale_go && !ovr_seen |-> ##3 result ==
            32'((64'(averaged) * 64'(signed'(mult))) >>> 16) + offset)
        else $error("scaling wrong");
    chk_nan_out: assert property (@(posedge mclk) disable iff (!reset_n)
        scale_go && ovr_seen |-> ##3 result == meas_pkg::NAN_CODE)
        else $error("overrange not nan");
    chk_busy_done: assert property (@(posedge mclk) disable iff (!reset_n)
        done |-> busy ##1 !busy && !done)
        else $error("done strobe wrong");
endmodule // voltage_measurement_sequencer

//--- testbench/afe_model.sv
// Purpose: behavioural front end and converter facing the sequencer
// Assumes: one conversion in flight, latency in cycles given by the bench (1 or more)
// Notes: reversal flips the signal but not the fixed sensor offset, so pairing must cancel it
module afe_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire meas_pkg::afe_ctrl_s afe,
    input wire logic conv_start,
    input wire logic [15:0] lat,
    input wire logic ovr_req,
    output logic conv_valid,
    output logic signed [meas_pkg::DATA_W-1:0] conv_data,
    output logic conv_overrange,
    output int n_starts
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SENSOR_OFS = 6;
    logic [15:0] cnt;
    logic signed [meas_pkg::DATA_W-1:0] sig;
    // channel n reads 1000*(n+1) against ground or its paired low terminal
    assign sig = 24'(1000 * (int'(afe.mux_high) + 1));
    always @(posedge mclk) begin
        if (!reset_n) begin
            cnt <= '0;
            n_starts <= 0;
            conv_valid <= 1'b0;
            conv_overrange <= 1'b0;
            conv_data <= '0;
        end else begin
            conv_valid <= 1'b0;
            conv_overrange <= 1'b0;
            if (conv_start) begin
                cnt <= lat;
                n_starts <= n_starts + 1;
            end else if (cnt != 16'h0000) begin
                cnt <= cnt - 16'h0001;
            end
            if (!conv_start && cnt == 16'h0001) begin
                conv_valid <= 1'b1;
                conv_overrange <= ovr_req;
                // swapped inputs or inverted excitation both flip the bridge output
                conv_data <= ((afe.swap_inputs ^ afe.exc_invert) ? -sig : sig)
                    + 24'(SENSOR_OFS);
            end else begin
                // no stale value between results
                conv_data <= ~conv_data;
            end
        end
    end
endmodule // afe_model

//--- testbench/voltage_measurement_sequencer_tb.sv
// Purpose: self-checking bench for the measurement sequencer
// Assumes: settle register 1 gives 100 cycles; one AHB-Lite master
// Notes: result expectations derive from the front-end model's fixed signal law
module voltage_measurement_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, reset_n, hsel, hwrite, ovr_req;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] lat;
    wire hreadyout, hresp, conv_start, conv_valid, conv_overrange, busy, done, irq;
    wire signed [meas_pkg::DATA_W-1:0] conv_data;
    meas_pkg::afe_ctrl_s afe, prev_afe, seen_afe;
    int failures, total_checks, gap, n_starts, n0;
    logic inv_seen;
    voltage_measurement_sequencer i_voltage_measurement_sequencer (.mclk(mclk),
        .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .afe(afe), .conv_start(conv_start),
        .conv_valid(conv_valid), .conv_data(conv_data), .conv_overrange(conv_overrange),
        .busy(busy), .done(done), .irq(irq));
    afe_model i_afe_model (.mclk(mclk), .reset_n(reset_n), .afe(afe),
        .conv_start(conv_start), .lat(lat), .ovr_req(ovr_req), .conv_valid(conv_valid),
        .conv_data(conv_data), .conv_overrange(conv_overrange), .n_starts(n_starts));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(name, 64'(exp), 64'(rd));
    endtask
    function automatic logic [31:0] cfg_w(int rng, int ch, logic d, logic ex, logic ir,
        logic xr, int mv);
        return 32'(rng) << meas_pkg::CFG_RANGE_LSB | 32'(rng + 4) << meas_pkg::CFG_NOTCH_LSB
            | 32'(ch) << meas_pkg::CFG_CHAN_LSB | 32'(d) << meas_pkg::CFG_DIFF_BIT
            | 32'(ex) << meas_pkg::CFG_EXC_EN_BIT | 32'(ir) << meas_pkg::CFG_IREV_BIT
            | 32'(xr) << meas_pkg::CFG_XREV_BIT | 32'(mv) << meas_pkg::CFG_EXC_MV_LSB;
    endfunction
    task automatic start_meas(input logic [31:0] cfg);
        n0 = n_starts;
        inv_seen = 1'b0;
        bus(1'b1, meas_pkg::OFF_CFG, cfg);
        bus(1'b1, meas_pkg::OFF_CTRL, 32'h0000_0001);
        @(posedge mclk);
        chk("busy", 64'h1, 64'(busy));
    endtask
    task automatic finish_meas(input int passes, input logic [31:0] exp);
        int k;
        for (k = 0; k < 6000 && done !== 1'b1; k++) @(posedge mclk);
        chk("done", 64'h1, 64'(done));
        chk("passes", 64'(passes), 64'(n_starts - n0));
        rd_chk("result", meas_pkg::OFF_RESULT, exp);
    endtask
    // every conversion must follow the last front-end change by the settle time
    always @(posedge mclk) begin
        prev_afe <= afe;
        gap <= (afe !== prev_afe) ? 0 : gap + 1;
        if (conv_start === 1'b1) begin
            seen_afe <= afe;
            inv_seen <= inv_seen | afe.exc_invert;
            chk("settle_gap_ok", 64'h1, 64'(gap >= 100));
        end
    end
    task automatic t_reset;
        rd_chk("cfg", meas_pkg::OFF_CFG, meas_pkg::CFG_RESET);
        rd_chk("settle", meas_pkg::OFF_SETTLE, meas_pkg::SETTLE_RESET);
        rd_chk("mult", meas_pkg::OFF_MULT, meas_pkg::MULT_RESET);
        rd_chk("offset", meas_pkg::OFF_OFFSET, meas_pkg::OFFSET_RESET);
        rd_chk("status", meas_pkg::OFF_STATUS, 32'(meas_pkg::ST_IDLE));
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b1, meas_pkg::OFF_RESULT, 32'h1234_5678);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        rd_chk("result_ro", meas_pkg::OFF_RESULT, 32'h0000_0000);
        chk("irq", 64'h0, 64'(irq));
        chk("hresp", 64'h0, 64'(hresp));
        bus(1'b1, meas_pkg::OFF_SETTLE, 32'h0000_0001);
        $display("test reset done");
    endtask
    task automatic t_single;
        bus(1'b1, meas_pkg::OFF_IRQ_EN, 32'h0000_0001);
        start_meas(cfg_w(5, 3, 1'b0, 1'b0, 1'b0, 1'b0, 0));
        finish_meas(1, 32'd4006);
        chk("afe_se", {4'd5, 4'd9, 4'd3, 1'b1, 1'b0}, {seen_afe.gain,
            seen_afe.first_notch_frequency, seen_afe.mux_high, seen_afe.low_to_ground,
            seen_afe.exc_on});
        chk("irq_on", 64'h1, 64'(irq));
        rd_chk("irq_stat", meas_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        bus(1'b1, meas_pkg::OFF_IRQ_CLR, 32'h0000_0003);
        @(posedge mclk);
        chk("irq_off", 64'h0, 64'(irq));
        $display("test single ended done");
    endtask
    task automatic t_diff;
        bus(1'b1, meas_pkg::OFF_MULT, 32'h0002_0000);
        bus(1'b1, meas_pkg::OFF_OFFSET, 32'hFFFF_FFFB);
        start_meas(cfg_w(2, 5, 1'b1, 1'b0, 1'b1, 1'b0, 0));
        finish_meas(2, 32'd11995);
        chk("afe_diff", {4'd5, 4'd5, 1'b0}, {seen_afe.mux_high, seen_afe.mux_low,
            seen_afe.low_to_ground});
        bus(1'b1, meas_pkg::OFF_MULT, meas_pkg::MULT_RESET);
        bus(1'b1, meas_pkg::OFF_OFFSET, meas_pkg::OFFSET_RESET);
        $display("test differential done");
    endtask
    task automatic t_exc;
        start_meas(cfg_w(1, 2, 1'b1, 1'b1, 1'b1, 1'b1, 2500));
        finish_meas(4, 32'd3000);
        chk("exc_at_conv", {1'b1, 16'd2500, 1'b1}, {seen_afe.exc_on,
            seen_afe.excitation_level_mv, inv_seen});
        chk("exc_off", 64'h0, 64'(afe.exc_on));
        $display("test excitation reverse done");
    endtask
    task automatic t_busy_ovr;
        lat <= 16'd300;
        ovr_req <= 1'b1;
        start_meas(cfg_w(3, 1, 1'b0, 1'b0, 1'b0, 1'b0, 0));
        bus(1'b1, meas_pkg::OFF_CFG, 32'h0000_0F0F);
        bus(1'b1, meas_pkg::OFF_CTRL, 32'h0000_0001);
        finish_meas(1, meas_pkg::NAN_CODE);
        rd_chk("cfg_held", meas_pkg::OFF_CFG, cfg_w(3, 1, 1'b0, 1'b0, 1'b0, 1'b0, 0));
        rd_chk("irq_stat_ovr", meas_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        chk("idle_after", 64'h0, 64'(busy));
        ovr_req <= 1'b0;
        lat <= 16'd3;
        $display("test busy and overrange done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        wrap_up();
    end
    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
        lat = 16'd3;
        ovr_req = 1'b0;
        failures = 0;
        total_checks = 0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_single();
        t_diff();
        t_exc();
        t_busy_ovr();
        wrap_up();
    end
endmodule // voltage_measurement_sequencer_tb
